//--- hdl/urf_top.sv
// Receive FIFO with trigger and idle status flags behind an AXI4-Lite slave.
// Assumes one 50 MHz clock, synchronous active-high reset, and an asynchronous serial line on rx_pin.
//
// Overview of operation
// - Set trigger flag when a stored character makes count exceed trigger level.
// - Reset clears the trigger flag to zero.
// - Trigger flag clears after read-one, write-zero, then draining below trigger level.
// - Reading an empty FIFO returns undefined data, no prior value kept.
// - Report receive entry count in low eight bits of count register.
// - Async mode: set idle flag below trigger level after 15 bit times quiet.
// - Synchronous mode never sets the idle flag.
// - Reset clears the idle flag to zero.
// - Idle flag clears after read-one, write-zero, then FIFO fully emptied.
// - Idle timeout equals one and a half 8N1 frames.
// - Only a written zero acts on the flags; a written one changes nothing.
`timescale 1ns/1ns
`default_nettype none
module urf_top
	import urf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial line and interrupt.
	input  wire logic        rx_pin,
	output logic             irq
);
	// ==========================================================================
	// State.
	// ==========================================================================
	typedef struct packed {
		logic [1:0]       sync;
		logic [CNT_W-1:0] wp;
		logic [CNT_W-1:0] rp;
		logic [CNT_W-1:0] cnt;
		logic             rx_trigger_flag;
		logic             rx_idle_flag;
		logic             trig_armed;
		logic             idle_armed;
		logic             trig_seen;
		logic             idle_seen;
		logic [3:0]       idle_bits;
		logic             idle_run;
		logic [31:0]      ctrl;
		logic [15:0]      baud;
		logic [1:0]       irq_st;
		logic [1:0]       irq_msk;
		logic             irq;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       aw_addr;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} urf_top_st_t;

	urf_top_st_t s_reg, s_next;
	logic [7:0]  fifo_mem [DEPTH];
	logic        os_tick;
	logic        bit_tick;
	urf_char_t   rx_char;
	logic [CNT_W-1:0] trig_lvl;
	logic        push;
	logic        pop;
	logic        wr_fire;
	logic        rd_fire;

	// ==========================================================================
	// Serial front end.
	// ==========================================================================
	urf_baud_gen u_baud (
		.clk     (clk),
		.reset   (reset),
		.divisor (s_reg.baud),
		.os_tick (os_tick)
	);

	urf_rx_shift u_shift (
		.clk      (clk),
		.reset    (reset),
		.os_tick  (os_tick),
		.rx_line  (s_reg.sync[1]),
		.char_out (rx_char),
		.bit_tick (bit_tick)
	);

	// Trigger level and handshake strobes.
	assign trig_lvl = urf_trig_level({s_reg.ctrl[BIT_SEL_HI], s_reg.ctrl[BIT_SEL_LO]});
	assign push     = rx_char.valid && s_reg.ctrl[BIT_ENABLE] && (s_reg.cnt != CNT_W'(DEPTH));
	assign wr_fire  = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
	assign rd_fire  = s_axi_arvalid && !s_reg.rvalid;
	assign pop      = rd_fire && (s_axi_araddr == ADDR_DATA) && (s_reg.cnt != '0);

	// Character storage; an empty read simply returns whatever sits at the read pointer.
	always_ff @(posedge clk) begin
		if (push)
			fifo_mem[s_reg.wp[3:0]] <= rx_char.data;
	end

	// ==========================================================================
	// Next state.
	// ==========================================================================
	always_comb begin
		logic [CNT_W-1:0] cnt_n;
		logic [1:0]       ev;
		cnt_n = s_reg.cnt;
		ev = 2'b00;
		s_next = s_reg;
		s_next.sync = {s_reg.sync[0], rx_pin};

		// FIFO pointers and count.
		if (push) begin
			s_next.wp = s_reg.wp + 5'h01;
		end
		if (pop) begin
			s_next.rp = s_reg.rp + 5'h01;
		end
		cnt_n = s_reg.cnt + CNT_W'(push) - CNT_W'(pop);
		s_next.cnt = cnt_n;

		// clear after drain: armed write-zero clears once count falls below level.
		if (s_reg.trig_armed && cnt_n < trig_lvl) begin
			s_next.rx_trigger_flag = 1'b0;
			s_next.trig_armed = 1'b0;
		end
		// clear after empty: armed write-zero clears once FIFO empties.
		if (s_reg.idle_armed && cnt_n == '0) begin
			s_next.rx_idle_flag = 1'b0;
			s_next.idle_armed = 1'b0;
		end

		// idle timer: restarts on stop bit, counts bit ticks only while nonempty.
		if (rx_char.valid) begin
			s_next.idle_bits = 4'h0;
			s_next.idle_run = 1'b1;
		end else if (s_reg.cnt == '0) begin
			s_next.idle_run = 1'b0;
		end else if (bit_tick && s_reg.idle_run && s_reg.idle_bits != 4'(IDLE_ETU)) begin
			s_next.idle_bits = s_reg.idle_bits + 4'h1;
		end

		// trigger set: stored count exceeds level; set wins over clear.
		if (push && cnt_n > trig_lvl) begin
			s_next.rx_trigger_flag = 1'b1;
			s_next.trig_armed = 1'b0;
			ev[BIT_TRIG] = 1'b1;
		end
		// idle set: 15 bit periods quiet below trigger level, async only.
		// sync mode: synchronous mode blocks the set entirely.
		if (!s_reg.ctrl[BIT_SYNC] && s_reg.idle_run && s_reg.idle_bits == 4'(IDLE_ETU)
			&& s_reg.cnt != '0 && s_reg.cnt < trig_lvl && !rx_char.valid) begin
			if (!s_reg.rx_idle_flag)
				ev[BIT_IDLE] = 1'b1;
			s_next.rx_idle_flag = 1'b1;
			s_next.idle_armed = 1'b0;
			s_next.idle_run = 1'b0;
		end

		// AXI write channels taken in either order.
		if (s_axi_awvalid && !s_reg.aw_got) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_got) begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			if (s_reg.aw_addr == ADDR_STATUS) begin
				// zero only: a written zero after a read of one arms the clear.
				if (s_reg.w_strb[0] && !s_reg.w_data[BIT_TRIG] && s_reg.trig_seen && s_reg.rx_trigger_flag)
					s_next.trig_armed = 1'b1;
				if (s_reg.w_strb[0] && !s_reg.w_data[BIT_IDLE] && s_reg.idle_seen && s_reg.rx_idle_flag)
					s_next.idle_armed = 1'b1;
			end else if (s_reg.aw_addr == ADDR_CONTROL) begin
				if (s_reg.w_strb[0])
					s_next.ctrl[7:0] = s_reg.w_data[7:0];
			end else if (s_reg.aw_addr == ADDR_IRQ_ST) begin
				if (s_reg.w_strb[0])
					s_next.irq_st = s_reg.irq_st & ~s_reg.w_data[1:0];
			end else if (s_reg.aw_addr == ADDR_IRQ_MSK) begin
				if (s_reg.w_strb[0])
					s_next.irq_msk = s_reg.w_data[1:0];
			end else if (s_reg.aw_addr == ADDR_BAUD) begin
				if (s_reg.w_strb[0])
					s_next.baud[7:0] = s_reg.w_data[7:0];
				if (s_reg.w_strb[1])
					s_next.baud[15:8] = s_reg.w_data[15:8];
			end else if (s_reg.aw_addr != ADDR_COUNT && s_reg.aw_addr != ADDR_DATA) begin
				s_next.bresp = RESP_SLVERR;
			end
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;

		// AXI read.
		if (rd_fire) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			s_next.rdata = 32'h0000_0000;
			if (s_axi_araddr == ADDR_STATUS) begin
				s_next.rdata[BIT_TRIG] = s_reg.rx_trigger_flag;
				s_next.rdata[BIT_IDLE] = s_reg.rx_idle_flag;
				s_next.trig_seen = s_reg.rx_trigger_flag;
				s_next.idle_seen = s_reg.rx_idle_flag;
			end else if (s_axi_araddr == ADDR_CONTROL) begin
				s_next.rdata = s_reg.ctrl;
			end else if (s_axi_araddr == ADDR_COUNT) begin
				// count field: entry count in the low eight bits.
				s_next.rdata[7:0] = 8'(s_reg.cnt);
			end else if (s_axi_araddr == ADDR_DATA) begin
				// empty read: value at read pointer, undefined by contract.
				s_next.rdata[7:0] = fifo_mem[s_reg.rp[3:0]];
			end else if (s_axi_araddr == ADDR_IRQ_ST) begin
				s_next.rdata[1:0] = s_reg.irq_st;
			end else if (s_axi_araddr == ADDR_IRQ_MSK) begin
				s_next.rdata[1:0] = s_reg.irq_msk;
			end else if (s_axi_araddr == ADDR_BAUD) begin
				s_next.rdata[15:0] = s_reg.baud;
			end else begin
				s_next.rresp = RESP_SLVERR;
			end
		end
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;

		// Sticky events win over the write-one clear above.
		s_next.irq_st = s_next.irq_st | ev;
		s_next.irq = |(s_next.irq_st & s_next.irq_msk);
	end

	// ==========================================================================
	// State register.
	// ==========================================================================
	// reset clear: both flags start at zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '{sync: 2'h3, ctrl: CONTROL_RESET, baud: BAUD_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops.
	assign s_axi_awready = !s_reg.aw_got;
	assign s_axi_wready  = !s_reg.w_got;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;
	assign irq           = s_reg.irq;

	// ==========================================================================
	// Checks.
	// ==========================================================================
	chk_trig_set_push: assert property (@(posedge clk) disable iff (reset)
		(push && (s_reg.cnt + 5'h01) > trig_lvl && !pop) |=> s_reg.rx_trigger_flag)
		else $error("trigger flag not set after count passed level");
	chk_trig_reset_zero: assert property (@(posedge clk) $past(reset) |-> !s_reg.rx_trigger_flag)
		else $error("trigger flag not zero after reset");
	chk_trig_clear_path: assert property (@(posedge clk) disable iff (reset)
		($fell(s_reg.rx_trigger_flag)) |-> $past(s_reg.trig_armed) && s_reg.cnt < trig_lvl)
		else $error("trigger flag cleared without armed drain");
	chk_count_field: assert property (@(posedge clk) disable iff (reset)
		(rd_fire && s_axi_araddr == ADDR_COUNT) |=> s_axi_rdata == {24'h0, 8'($past(s_reg.cnt))})
		else $error("count register does not show entry count");
	chk_idle_async_set: assert property (@(posedge clk) disable iff (reset)
		$rose(s_reg.rx_idle_flag) |-> $past(s_reg.idle_bits) == 4'(IDLE_ETU) && $past(s_reg.cnt) < trig_lvl)
		else $error("idle flag set before 15 quiet bit times");
	chk_idle_sync_never: assert property (@(posedge clk) disable iff (reset)
		($past(s_reg.ctrl[BIT_SYNC]) && !$past(s_reg.rx_idle_flag)) |-> !s_reg.rx_idle_flag)
		else $error("idle flag set in synchronous mode");
	chk_idle_reset_zero: assert property (@(posedge clk) $past(reset) |-> !s_reg.rx_idle_flag)
		else $error("idle flag not zero after reset");
	chk_idle_clear_empty: assert property (@(posedge clk) disable iff (reset)
		$fell(s_reg.rx_idle_flag) |-> s_reg.cnt == '0)
		else $error("idle flag cleared while FIFO not empty");
	chk_write_one_keeps: assert property (@(posedge clk) disable iff (reset)
		(wr_fire && s_reg.aw_addr == ADDR_STATUS && s_reg.w_data[BIT_TRIG] && !s_reg.trig_armed)
		|=> !s_reg.trig_armed)
		else $error("writing one armed the trigger clear");
endmodule // urf_top
`default_nettype wire

//--- hdl/urf_pkg.sv
// Package for the receive FIFO status flag block: register map, field layout, resets, timing.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package urf_pkg;

	// ==========================================================================
	// Register offsets (byte addresses).
	// ==========================================================================
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_COUNT   = 8'h08;
	localparam logic [7:0] ADDR_DATA    = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;
	localparam logic [7:0] ADDR_BAUD    = 8'h18;

	// ==========================================================================
	// Field positions, FIFO depth and count width.
	// ==========================================================================
	localparam int BIT_IDLE     = 0;
	localparam int BIT_TRIG     = 1;
	localparam int BIT_SEL_LO   = 0;
	localparam int BIT_SEL_HI   = 1;
	localparam int BIT_SYNC     = 2;
	localparam int BIT_ENABLE   = 3;
	localparam int FIFO_DEPTH   = 16;
	localparam int CNT_W        = 5;

	// ==========================================================================
	// Reset values, timing and response codes.
	// ==========================================================================
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0008;
	localparam logic [15:0] BAUD_RESET    = 16'h01B2;
	localparam int          IDLE_ETU      = 15;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Trigger level for each code of the two select bits.
	function automatic logic [CNT_W-1:0] urf_trig_level(input logic [1:0] sel);
		case (sel)
			2'h0: urf_trig_level = 5'h01;
			2'h1: urf_trig_level = 5'h04;
			2'h2: urf_trig_level = 5'h08;
			default: urf_trig_level = 5'h0E;
		endcase
	endfunction

	// Received character carrier.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       stop;
	} urf_char_t;

endpackage

//--- hdl/urf_rx_shift.sv
// Serial receiver: samples the line on a 16x oversample enable, emits one character per frame.
// Assumes the line is already synchronised and one stop bit of 8N1 framing.
`timescale 1ns/1ns
`default_nettype none
module urf_rx_shift
	import urf_pkg::*;
(
	// Clock and reset.
	input  wire logic      clk,
	input  wire logic      reset,
	// Oversample enable and synchronised line.
	input  wire logic      os_tick,
	input  wire logic      rx_line,
	// Received character and bit tick.
	output urf_char_t      char_out,
	output logic           bit_tick
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_DATA  = 4'b0100,
		ST_STOP  = 4'b1000
	} urf_rx_state_t;

	typedef struct packed {
		urf_rx_state_t st;
		logic [3:0]    os;
		logic [2:0]    bits;
		logic [7:0]    sh;
		urf_char_t     ch;
		logic          bt;
	} urf_rx_t;

	urf_rx_t s_reg, s_next;

	// Next state: mid-bit sampling at oversample count 7 of start, 15 afterwards.
	always_comb begin
		s_next = s_reg;
		s_next.ch.valid = 1'b0;
		s_next.bt = 1'b0;
		if (os_tick) begin
			s_next.os = s_reg.os + 4'h1;
			if (s_reg.os == 4'hF)
				s_next.bt = 1'b1;
			case (s_reg.st)
				ST_IDLE: begin
					// The phase runs free while the line rests, so bit ticks keep the idle timer going.
					if (!rx_line) begin
						s_next.os = 4'h0;
						s_next.st = ST_START;
					end
				end
				ST_START: begin
					if (s_reg.os == 4'h7) begin
						s_next.os = 4'h0;
						s_next.bits = 3'h0;
						s_next.st = rx_line ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (s_reg.os == 4'hF) begin
						s_next.sh = {rx_line, s_reg.sh[7:1]};
						s_next.bits = s_reg.bits + 3'h1;
						if (s_reg.bits == 3'h7)
							s_next.st = ST_STOP;
					end
				end
				default: begin
					if (s_reg.os == 4'hF) begin
						s_next.ch.valid = 1'b1;
						s_next.ch.data = s_reg.sh;
						s_next.ch.stop = rx_line;
						s_next.st = ST_IDLE;
					end
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '{st: ST_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign char_out = s_reg.ch;
	assign bit_tick = s_reg.bt;
endmodule // urf_rx_shift
`default_nettype wire

//--- hdl/urf_baud_gen.sv
// Baud divider: one-cycle 16x oversample enable pulse from a programmable divisor.
// Assumes the divisor is stable while characters are in flight.
`timescale 1ns/1ns
`default_nettype none
module urf_baud_gen
	import urf_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset,
	// Divisor in clock cycles per oversample tick, minus one.
	input  wire logic [15:0] divisor,
	// Oversample enable.
	output logic             os_tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} urf_bg_t;

	urf_bg_t s_reg, s_next;

	// Count down and pulse at zero.
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.cnt == 16'h0000) begin
			s_next.cnt = divisor;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt - 16'h0001;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign os_tick = s_reg.tick;
endmodule // urf_baud_gen
`default_nettype wire

//--- bench/urf_line_src.sv
// Remote serial source: sends one 8N1 frame per request, least significant bit first.
// Assumes go is held until busy is seen high; the line rests at mark level between frames.
`timescale 1ns/1ns
`default_nettype none
module urf_line_src #(
	parameter int BIT_CLKS = 32
) (
	// Clock.
	input  wire logic       clk,
	// Frame request.
	input  wire logic       go,
	input  wire logic [7:0] tx_byte,
	output logic            busy,
	// Serial line.
	output logic            line
);
	// ==========================================================================
	// Frame generator
	// ==========================================================================
	logic [9:0] frame;

	// Start bit, eight data bits and one stop bit, then back to mark.
	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				frame = {1'b1, tx_byte, 1'b0};
				busy <= 1'b1;
				for (int i = 0; i < 10; i++) begin
					line <= frame[i];
					repeat (BIT_CLKS) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // urf_line_src
`default_nettype wire

//--- bench/uart_rx_fifo_status_flags_tb.sv
// Self-checking bench for the receive flag block: AXI4-Lite master, serial source, checks.
// Assumes the serial source model in urf_line_src and a short baud divisor to keep runs brief.
`timescale 1ns/1ns
`default_nettype none
module uart_rx_fifo_status_flags_tb;
	import urf_pkg::*;
	// ==========================================================================
	// Signals
	// ==========================================================================
	localparam int DIV  = 1;
	localparam int BITC = 16 * (DIV + 1);
	logic        clk, reset, rx_pin, irq, go, busy;
	logic [7:0]  awaddr, araddr, tx_byte;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd, seed;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	int          bad_count, n_tests;
	logic [7:0]  exp_q[$];

	urf_top DUT (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(rx_pin), .irq(irq));
	urf_line_src #(.BIT_CLKS(BITC)) SRC (.clk(clk), .go(go), .tx_byte(tx_byte), .busy(busy), .line(rx_pin));

	// The 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Entry count that the flag must exceed for each select code.
	function automatic int lvl(input int sel);
		case (sel)
			0: return 1;
			1: return 4;
			2: return 8;
			default: return 14;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	// Bus write: both channels offered together, each released when taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	// Bus read: data and response taken at the edge where rvalid is sampled.
	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// One random character over the line; the expected copy goes to the queue.
	task automatic send();
		seed = xs(seed);
		@(posedge clk);
		go <= 1'b1;
		tx_byte <= seed[7:0];
		exp_q.push_back(seed[7:0]);
		do @(posedge clk); while (!busy);
		go <= 1'b0;
		do @(posedge clk); while (busy);
	endtask

	task automatic drain1();
		axr(ADDR_DATA);
		chk("rx data", {24'h0, exp_q.pop_front()}, {24'h0, rd[7:0]});
	endtask

	task automatic waitb(input int n);
		repeat (n * BITC) @(posedge clk);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready, go} = 7'h40;
		{awaddr, araddr, tx_byte, wdata, wstrb} = '0;
		seed = 32'hF8DB19E2;
		bad_count = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		axr(ADDR_STATUS);
		chk("status reset", 32'h0, rd);
		axr(ADDR_COUNT);
		chk("count reset", 32'h0, rd & 32'hFF);
		axr(8'h1C);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		axw(8'h1C, 32'hFFFFFFFF);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		axw(ADDR_BAUD, DIV);
		axw(ADDR_IRQ_MSK, 32'h3);
		// The divider loads a new divisor only at its next reload, so the old count is waited out.
		repeat (BAUD_RESET + 16'h0002) @(posedge clk);
		$display("test reset done");
		// Every trigger select code: boundary at the level, one above it, then the clear handshake.
		for (int s = 0; s < 4; s++) begin
			axw(ADDR_CONTROL, 32'h8 | s);
			repeat (lvl(s)) send();
			axr(ADDR_STATUS);
			chk("flag at level", 32'h0, rd & 32'h2);
			send();
			axr(ADDR_STATUS);
			chk("flag above level", 32'h2, rd & 32'h2);
			axr(ADDR_COUNT);
			chk("count above level", lvl(s) + 1, rd & 32'hFF);
			if (s == 0) begin
				repeat (2) @(posedge clk);
				chk("irq raised", 32'h1, {31'h0, irq});
				axw(ADDR_IRQ_MSK, 32'h0);
				repeat (2) @(posedge clk);
				chk("irq masked", 32'h0, {31'h0, irq});
				axw(ADDR_IRQ_MSK, 32'h3);
				axw(ADDR_IRQ_ST, 32'h3);
				axr(ADDR_IRQ_ST);
				chk("irq status cleared", 32'h0, rd & 32'h3);
				chk("irq low", 32'h0, {31'h0, irq});
			end
			axw(ADDR_STATUS, 32'h3);
			axr(ADDR_STATUS);
			chk("write one keeps flag", 32'h2, rd & 32'h2);
			axw(ADDR_STATUS, 32'h0);
			drain1();
			axr(ADDR_STATUS);
			chk("flag held at level", 32'h2, rd & 32'h2);
			drain1();
			axr(ADDR_STATUS);
			chk("flag cleared below", 32'h0, rd & 32'h2);
			while (exp_q.size() > 0) drain1();
			axr(ADDR_COUNT);
			chk("count drained", 32'h0, rd & 32'hFF);
			$display("test trigger level %0d done", lvl(s));
		end
		axr(ADDR_DATA);
		axr(ADDR_COUNT);
		chk("empty read no pop", 32'h0, rd & 32'hFF);
		// Quiet line below the level: idle flag after fifteen bit times.
		axw(ADDR_CONTROL, 32'h9);
		repeat (2) send();
		waitb(12);
		axr(ADDR_STATUS);
		chk("idle early", 32'h0, rd & 32'h1);
		waitb(5);
		axr(ADDR_STATUS);
		chk("idle after quiet", 32'h1, rd & 32'h1);
		axr(ADDR_IRQ_ST);
		chk("idle event", 32'h1, rd & 32'h1);
		axr(ADDR_STATUS);
		axw(ADDR_STATUS, 32'h0);
		drain1();
		axr(ADDR_STATUS);
		chk("idle held nonempty", 32'h1, rd & 32'h1);
		drain1();
		axr(ADDR_STATUS);
		chk("idle cleared empty", 32'h0, rd & 32'h1);
		waitb(18);
		axr(ADDR_STATUS);
		chk("no idle when empty", 32'h0, rd & 32'h1);
		$display("test idle done");
		// Synchronous mode never raises the idle flag.
		axw(ADDR_CONTROL, 32'hD);
		send();
		waitb(18);
		axr(ADDR_STATUS);
		chk("no idle sync", 32'h0, rd & 32'h1);
		// With the receiver disabled a character on the line must not reach the FIFO.
		axw(ADDR_CONTROL, 32'h5);
		send();
		axr(ADDR_COUNT);
		chk("disabled no push", 32'h1, rd & 32'hFF);
		exp_q.delete();
		$display("test sync done");
		give_verdict();
	end

	// Watchdog well beyond the expected run of some fourteen thousand cycles.
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		$display("[FAIL] watchdog expired");
		give_verdict();
	end
endmodule // uart_rx_fifo_status_flags_tb
`default_nettype wire
